// File: hw/acp_clkdiv.sv
`timescale 1ns/10ps
module acp_clkdiv #(
   parameter int CNT_W = 6
) (
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // selection
   input  wire logic [2:0] code_i,
   input  wire logic       rc_lvl_i,
   output logic            conv_clk_o
);
   import acp_pkg::*;

   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] half;
   logic             use_rc;
   logic             wrap;

   // half period in device clocks for each divided code
   function automatic logic [CNT_W-1:0] acp_half(input logic [2:0] c);
      logic [CNT_W-1:0] h;
      h = CNT_W'(1);
      case (c)
         3'h1:    h = CNT_W'(4);
         3'h2:    h = CNT_W'(16);
         3'h4:    h = CNT_W'(2);
         3'h5:    h = CNT_W'(8);
         3'h6:    h = CNT_W'(32 - 1) + CNT_W'(1);
         default: h = CNT_W'(1);
      endcase
      return h;
   endfunction : acp_half

   assign half   = acp_half(code_i);
   assign use_rc = (code_i == CLK_RC_A) || (code_i == CLK_RC_B); // R5
   assign wrap   = (cnt_reg + CNT_W'(1)) == half;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_reg    <= '0;
         conv_clk_o <= 1'b0;
      end else if (use_rc) begin
         cnt_reg    <= '0;
         conv_clk_o <= rc_lvl_i;
      end else begin
         cnt_reg    <= wrap ? '0 : cnt_reg + CNT_W'(1);
         conv_clk_o <= wrap ? ~conv_clk_o : conv_clk_o; // R5
      end
   end
endmodule : acp_clkdiv

// File: hw/acp_pkg.sv
// Overview of operation
// (R1) six-bit channel code picks converter input; unlisted codes are reserved
// (R2) writing one to run bit starts conversion; it reads one until done; code clears it on a control write with run bit zero unless a trigger edge sets it
// (R3) enable bit zero holds converter off; one enables it
// (R4) justify one: right-justified, upper six zero; zero: left-justified, lower six zero
// (R5) clock code 111/011 picks rc clock, others divide device clock 2..64
// (R6) reference code 11 fixed, 10 external pin, 00 supply, 01 reserved
// (R7) four-bit trigger code picks auto-conversion source; unlisted codes reserved
// (R8) result held in 16 bits, high and low bytes at consecutive addresses
// (R9) pump mode 11 keeps pump enabled always
// (R10) pump mode 10 enables pump while supply below threshold
// (R11) pump mode 01 enables pump while converter on and supply below threshold
// (R12) pump mode resets to 00; cleared mode disables pump
// (R13) threshold bit reads one when supply above threshold
// (R14) ready bit reads one only after pump has settled
// (R15) rising edge of chosen trigger sets run bit by hardware
// (R16) on completion clear run bit, set done flag, load result
// (R17) bits 3 and 2 of format register ignore writes, read zero
package acp_pkg;
   // ------------------------------------------------------------
   // register indices, byte address is four times the index
   // ------------------------------------------------------------
   localparam logic [7:0] IDX_PUMP   = 8'h9A;
   localparam logic [7:0] IDX_RES_LO = 8'h9B;
   localparam logic [7:0] IDX_RES_HI = 8'h9C;
   localparam logic [7:0] IDX_CTRL0  = 8'h9D;
   localparam logic [7:0] IDX_CTRL1  = 8'h9E;
   localparam logic [7:0] IDX_TRIG   = 8'h9F;
   localparam logic [7:0] IDX_STAT   = 8'hA0;
   localparam logic [7:0] IDX_MASK   = 8'hA1;
   // ------------------------------------------------------------
   // field positions, masks and reset values
   // ------------------------------------------------------------
   localparam int         CH_LSB     = 2;
   localparam int         GO_BIT     = 1;
   localparam int         ON_BIT     = 0;
   localparam int         JUST_BIT   = 7;
   localparam int         CLK_LSB    = 4;
   localparam int         PUMP_LSB   = 6;
   localparam int         THR_BIT    = 1;
   localparam int         RDY_BIT    = 0;
   localparam logic [7:0] CTRL1_WMSK = 8'hF3;
   localparam logic [7:0] CTRL0_RST  = 8'h00;
   localparam logic [7:0] CTRL1_RST  = 8'h00;
   localparam logic [3:0] TRIG_RST   = 4'h0;
   localparam logic [15:0] RES_RST   = 16'h0000;
   localparam logic [1:0] PUMP_RST   = 2'h0;
   // ------------------------------------------------------------
   // codes
   // ------------------------------------------------------------
   localparam logic [5:0] CH_PORTA0  = 6'h00;
   localparam logic [5:0] CH_GROUND  = 6'h1B;
   localparam logic [5:0] CH_FIXREF1 = 6'h1E;
   localparam logic [2:0] CLK_RC_A   = 3'h7;
   localparam logic [2:0] CLK_RC_B   = 3'h3;
   localparam logic [1:0] REF_RSVD   = 2'h1;
   localparam logic [3:0] TRIG_PIN   = 4'h1;
   localparam logic [3:0] TRIG_HIRD  = 4'hD;
   localparam logic [1:0] PUMP_OFF   = 2'h0;
   localparam logic [1:0] PUMP_ANA   = 2'h1;
   localparam logic [1:0] PUMP_AUTO  = 2'h2;
   localparam logic [1:0] PUMP_ON    = 2'h3;
   localparam int         IRQ_DONE   = 0;
   localparam int         IRQ_RDY    = 1;
   localparam int         IRQ_W      = 2;
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int         CLK_NS     = 5;
   localparam int         SETTLE_NS  = 10000;
   localparam int         SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
endpackage : acp_pkg

// File: hw/acp_sync.sv
`timescale 1ns/10ps
module acp_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   // levels
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);
   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;
   logic [W-1:0] s3_reg;
   logic [W-1:0] agree;

   // only take a bit once stages two and three agree
   assign agree = ~(s2_reg ^ s3_reg);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
         sync_o <= '0;
      end else begin
         s1_reg <= async_i;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         sync_o <= (s2_reg & agree) | (sync_o & ~agree);
      end
   end
endmodule : acp_sync

// File: hw/acp_top.sv
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/10ps
module acp_top #(
   parameter int SETTLE = acp_pkg::SETTLE_CYC
) (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [9:2]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // converter core
   output logic             conv_en_o,
   output logic             conv_start_o,
   output logic      [5:0]  conv_chan_o,
   output logic             chan_listed_o,
   output logic      [1:0]  ref_sel_o,
   output logic             conv_clk_o,
   input  wire logic        core_done_i,
   input  wire logic [9:0]  core_data_i,
   // trigger sources
   input  wire logic        trig_pin_i,
   input  wire logic [9:2]  trig_hw_i,
   // pump and clocks
   input  wire logic        supply_above_i,
   input  wire logic        rc_clk_i,
   output logic             pump_en_o,
   // interrupt
   output logic             irq_o
);
   import acp_pkg::*;

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [5:0]        chan_reg;
   logic              go_reg;
   logic              on_reg;
   logic              just_reg;
   logic [2:0]        clk_sel_reg;
   logic [1:0]        ref_reg;
   logic [3:0]        trig_reg;
   logic [15:0]       res_reg;
   logic [1:0]        pmode_reg;
   logic              rdy_reg;
   logic [IRQ_W-1:0]  stat_reg;
   logic [IRQ_W-1:0]  mask_reg;
   logic              trig_prev_reg;
   logic [15:0]       settle_reg;
   logic              go_next;
   logic [IRQ_W-1:0]  stat_next;

   // ------------------------------------------------------------
   // synchronised pins
   // ------------------------------------------------------------
   logic [2:0]        pins_s;
   logic              pin_trig_s;
   logic              above_s;
   logic              rc_s;
   logic              div_clk;

   acp_sync #(
      .W (3)
   ) u_sync (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .async_i ({rc_clk_i, supply_above_i, trig_pin_i}),
      .sync_o  (pins_s)
   );

   assign pin_trig_s = pins_s[0];
   assign above_s    = pins_s[1];
   assign rc_s       = pins_s[2];

   acp_clkdiv #(
      .CNT_W (6)
   ) u_div (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .code_i     (clk_sel_reg),
      .rc_lvl_i   (rc_s),
      .conv_clk_o (div_clk)
   );

   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   logic [7:0]        idx;
   logic              req;
   logic              wr;
   logic              rd;
   logic [7:0]        wd;
   logic              wr_pump;
   logic              wr_lo;
   logic              wr_hi;
   logic              wr_c0;
   logic              wr_c1;
   logic              wr_trig;
   logic              wr_mask;
   logic              rd_hi;
   logic              rd_stat;

   assign idx     = wb_adr_i;
   assign req     = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr      = req && wb_we_i && wb_sel_i[0];
   assign rd      = req && !wb_we_i;
   assign wd      = wb_dat_i[7:0];
   assign wr_pump = wr && (idx == IDX_PUMP);
   assign wr_lo   = wr && (idx == IDX_RES_LO);
   assign wr_hi   = wr && (idx == IDX_RES_HI);
   assign wr_c0   = wr && (idx == IDX_CTRL0);
   assign wr_c1   = wr && (idx == IDX_CTRL1);
   assign wr_trig = wr && (idx == IDX_TRIG);
   assign wr_mask = wr && (idx == IDX_MASK);
   assign rd_hi   = rd && (idx == IDX_RES_HI);
   assign rd_stat = rd && (idx == IDX_STAT);

   // ------------------------------------------------------------
   // decode helpers
   // ------------------------------------------------------------
   function automatic logic acp_chan_ok(input logic [5:0] c);
      logic ok;
      ok = 1'b0;
      case (c)
         CH_PORTA0, 6'h01, 6'h02, 6'h04, 6'h05: ok = 1'b1;
         6'h0D, 6'h0E, 6'h0F:                   ok = 1'b1;
         6'h12, 6'h13, 6'h14, 6'h15:            ok = 1'b1;
         CH_GROUND, CH_FIXREF1:                 ok = 1'b1;
         default:                               ok = 1'b0;
      endcase
      return ok;
   endfunction : acp_chan_ok

   function automatic logic acp_trig_pick(
      input logic [3:0] c,
      input logic [9:2] hw,
      input logic       pin,
      input logic       hird
   );
      logic t;
      t = 1'b0;
      case (c)
         TRIG_PIN:  t = pin;
         4'h2:      t = hw[2];
         4'h3:      t = hw[3];
         4'h4:      t = hw[4];
         4'h5:      t = hw[5];
         4'h6:      t = hw[6];
         4'h7:      t = hw[7];
         4'h8:      t = hw[8];
         4'h9:      t = hw[9];
         TRIG_HIRD: t = hird;
         default:   t = 1'b0;
      endcase
      return t;
   endfunction : acp_trig_pick

   // ------------------------------------------------------------
   // conversion control
   // ------------------------------------------------------------
   logic              trig_now;
   logic              trig_rise;
   logic              on_next;
   logic              done;
   logic              go_set;
   logic [15:0]       res_fmt;

   assign trig_now  = acp_trig_pick(trig_reg, trig_hw_i, pin_trig_s, rd_hi); // R7
   assign trig_rise = trig_now && !trig_prev_reg; // R15
   assign on_next   = wr_c0 ? wd[ON_BIT] : on_reg;
   assign done      = go_reg && core_done_i;
   assign go_set    = on_next && ((wr_c0 && wd[GO_BIT]) || trig_rise); // R2 R15
   assign res_fmt   = just_reg ? {6'h00, core_data_i}
                               : {core_data_i, 6'h00}; // R4

   always_comb begin
      go_next = go_reg;
      if (!on_next) begin
         go_next = 1'b0; // R3
      end else if (go_set) begin
         go_next = 1'b1; // R2
      end else if (done) begin
         go_next = 1'b0; // R16
      end else if (wr_c0 && !wd[GO_BIT]) begin
         go_next = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         chan_reg      <= CTRL0_RST[7:2];
         on_reg        <= CTRL0_RST[ON_BIT];
         go_reg        <= CTRL0_RST[GO_BIT];
         trig_prev_reg <= 1'b0;
      end else begin
         if (wr_c0) begin
            chan_reg <= wd[7:CH_LSB]; // R1
         end
         on_reg        <= on_next; // R3
         go_reg        <= go_next;
         trig_prev_reg <= trig_now;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         just_reg    <= CTRL1_RST[JUST_BIT];
         clk_sel_reg <= CTRL1_RST[6:CLK_LSB];
         ref_reg     <= CTRL1_RST[1:0];
         trig_reg    <= TRIG_RST;
      end else begin
         if (wr_c1) begin
            just_reg    <= wd[JUST_BIT]; // R4
            clk_sel_reg <= wd[6:CLK_LSB]; // R5
            ref_reg     <= wd[1:0]; // R6
         end
         if (wr_trig) begin
            trig_reg <= wd[3:0]; // R7
         end
      end
   end

   // hardware load wins over a software byte write
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         res_reg <= RES_RST;
      end else if (done) begin
         res_reg <= res_fmt; // R16
      end else begin
         if (wr_lo) begin
            res_reg[7:0] <= wd; // R8
         end
         if (wr_hi) begin
            res_reg[15:8] <= wd; // R8
         end
      end
   end

   // ------------------------------------------------------------
   // charge pump
   // ------------------------------------------------------------
   logic              pump_want;
   logic              settled;

   assign pump_want = (pmode_reg == PUMP_ON)                      // R9
                   || ((pmode_reg == PUMP_AUTO) && !above_s)      // R10
                   || ((pmode_reg == PUMP_ANA) && on_reg && !above_s); // R11
   assign settled   = settle_reg == 16'(SETTLE - 1);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pmode_reg <= PUMP_RST; // R12
      end else if (wr_pump) begin
         pmode_reg <= wd[7:PUMP_LSB]; // R12
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || !pump_en_o) begin
         settle_reg <= '0;
         rdy_reg    <= 1'b0; // R14
      end else begin
         settle_reg <= settled ? settle_reg : settle_reg + 16'h0001;
         rdy_reg    <= settled; // R14
      end
   end

   // ------------------------------------------------------------
   // interrupt status, read clears, set wins
   // ------------------------------------------------------------
   logic [IRQ_W-1:0]  ev;
   logic              rdy_rise;
   logic              rdy_prev_reg;

   assign rdy_rise = rdy_reg && !rdy_prev_reg;
   assign ev       = {rdy_rise, done};

   always_comb begin
      stat_next = rd_stat ? '0 : stat_reg;
      stat_next = stat_next | ev; // R16
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stat_reg     <= '0;
         mask_reg     <= '0;
         rdy_prev_reg <= 1'b0;
      end else begin
         stat_reg     <= stat_next;
         rdy_prev_reg <= rdy_reg;
         if (wr_mask) begin
            mask_reg <= wd[IRQ_W-1:0];
         end
      end
   end

   // ------------------------------------------------------------
   // read mux
   // ------------------------------------------------------------
   logic [7:0]        rmux;

   always_comb begin
      rmux = 8'h00;
      case (idx)
         IDX_PUMP:   rmux = {pmode_reg, 4'h0, above_s, rdy_reg}; // R13 R14
         IDX_RES_LO: rmux = res_reg[7:0];
         IDX_RES_HI: rmux = res_reg[15:8];
         IDX_CTRL0:  rmux = {chan_reg, go_reg, on_reg}; // R2
         IDX_CTRL1:  rmux = {just_reg, clk_sel_reg, 2'h0, ref_reg}
                          & CTRL1_WMSK; // R17
         IDX_TRIG:   rmux = {4'h0, trig_reg};
         IDX_STAT:   rmux = {{(8 - IRQ_W){1'b0}}, stat_reg};
         IDX_MASK:   rmux = {{(8 - IRQ_W){1'b0}}, mask_reg};
         default:    rmux = 8'h00;
      endcase
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o      <= 1'b0;
         wb_dat_o      <= 32'h0000_0000;
         conv_en_o     <= 1'b0;
         conv_start_o  <= 1'b0;
         conv_chan_o   <= 6'h00;
         chan_listed_o <= 1'b0;
         ref_sel_o     <= 2'h0;
         conv_clk_o    <= 1'b0;
         pump_en_o     <= 1'b0;
         irq_o         <= 1'b0;
      end else begin
         wb_ack_o      <= req;
         wb_dat_o      <= rd ? {24'h00_0000, rmux} : 32'h0000_0000;
         conv_en_o     <= on_next; // R3
         conv_start_o  <= go_set && (!go_reg || done); // R2
         conv_chan_o   <= chan_reg; // R1
         chan_listed_o <= acp_chan_ok(chan_reg); // R1
         ref_sel_o     <= (ref_reg == REF_RSVD) ? 2'h0 : ref_reg; // R6
         conv_clk_o    <= on_reg && div_clk; // R5
         pump_en_o     <= pump_want; // R9 R10 R11 R12
         irq_o         <= |(stat_next & mask_reg);
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   a_go_write_start: assert property (wr_c0 && wd[GO_BIT] && wd[ON_BIT] |=> go_reg) // R2
      else $error("run bit not set by write");
   a_off_no_run: assert property (!on_reg |-> !go_reg && !conv_en_o) // R3
      else $error("run bit high while converter off");
   a_right_just: assert property (done && just_reg |=> res_reg[15:10] == 6'h00) // R4
      else $error("right justify upper bits not zero");
   a_left_just: assert property (done && !just_reg |=> res_reg[5:0] == 6'h00) // R4
      else $error("left justify lower bits not zero");
   a_pump_forced: assert property (pmode_reg == PUMP_ON |=> pump_en_o) // R9
      else $error("pump not on in forced mode");
   a_pump_auto: assert property (pmode_reg == PUMP_AUTO && above_s |=> !pump_en_o) // R10
      else $error("pump on above threshold");
   a_pump_analog: assert property (pmode_reg == PUMP_ANA && !on_reg |=> !pump_en_o) // R11
      else $error("pump on with converter off");
   a_pump_cleared: assert property (pmode_reg == PUMP_OFF |=> !pump_en_o) // R12
      else $error("pump on while mode cleared");
   a_ready_off: assert property (!pump_en_o |=> !rdy_reg) // R14
      else $error("ready set with pump off");
   a_ready_delay: assert property ($rose(pump_en_o) |-> !rdy_reg [*8]) // R14
      else $error("ready too early");
   a_trig_start: assert property (trig_rise && on_reg && !wr_c0 |=> go_reg) // R15
      else $error("trigger edge did not start conversion");
   a_done_ends: assert property (done && !go_set |=> !go_reg && stat_reg[IRQ_DONE]) // R16
      else $error("completion did not clear run or set flag");
   a_fmt_zero: assert property (wb_ack_o && $past(rd && idx == IDX_CTRL1)
                                |-> wb_dat_o[3:2] == 2'h0) // R17
      else $error("unimplemented format bits read nonzero");

   c_sw_conv: cover property (go_set ##[1:50] done);
   c_trig_conv: cover property (trig_rise && on_reg ##[1:50] done);
   c_pump_ready: cover property ($rose(rdy_reg));
   c_irq: cover property ($rose(irq_o));
endmodule : acp_top

// File: tb/acp_core_model.sv
`timescale 1ns/10ps
module acp_core_model #(
   parameter int DLY = 30
) (
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // converter side
   input  wire logic       start_i,
   input  wire logic [9:0] val_i,
   output logic            done_o,
   output logic [9:0]      data_o
);
   int cnt_reg;
   // data valid only with done, toggles otherwise
   always_ff @(posedge clk_i) begin
      done_o <= 1'b0;
      data_o <= ~data_o;
      if (rst_i) begin
         cnt_reg <= 0;
         data_o  <= 10'h000;
      end else if (start_i) begin
         cnt_reg <= DLY;
      end else if (cnt_reg == 1) begin
         cnt_reg <= 0;
         done_o  <= 1'b1;
         data_o  <= val_i;
      end else if (cnt_reg > 1) begin
         cnt_reg <= cnt_reg - 1;
      end
   end
endmodule : acp_core_model

// File: tb/adc_control_and_pump_enable_tb.sv
`timescale 1ns/10ps
module adc_control_and_pump_enable_tb;
   import acp_pkg::*;
   localparam int ST = 8;
   logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
   logic        wb_we_i = 1'b0, trig_pin_i = 1'b0, supply_above_i = 1'b1, rc_clk_i = 1'b0;
   logic [9:2]  wb_adr_i = 8'h00, trig_hw_i = 8'h00;
   logic [3:0]  wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
   logic        wb_ack_o, conv_en_o, conv_start_o, chan_listed_o, conv_clk_o;
   logic        core_done_i, pump_en_o, irq_o, jw, on, ab;
   logic [5:0]  conv_chan_o;
   logic [1:0]  ref_sel_o, m;
   logic [9:0]  core_data_i, val = 10'h000;
   logic [7:0]  q, d, h;
   time         t;
   logic [6:0]  ch_tab [5] = '{7'h40, 7'h5B, 7'h5E, 7'h03, 7'h1F};
   int          fails = 0, samples_checked = 0;

   acp_top #(.SETTLE(ST)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .conv_en_o(conv_en_o),
      .conv_start_o(conv_start_o), .conv_chan_o(conv_chan_o), .chan_listed_o(chan_listed_o),
      .ref_sel_o(ref_sel_o), .conv_clk_o(conv_clk_o), .core_done_i(core_done_i),
      .core_data_i(core_data_i), .trig_pin_i(trig_pin_i), .trig_hw_i(trig_hw_i),
      .supply_above_i(supply_above_i), .rc_clk_i(rc_clk_i), .pump_en_o(pump_en_o),
      .irq_o(irq_o));
   acp_core_model #(.DLY(30)) core (.clk_i(clk_i), .rst_i(rst_i), .start_i(conv_start_o),
      .val_i(val), .done_o(core_done_i), .data_o(core_data_i));

   initial begin
      forever #2.5 clk_i = ~clk_i;
   end
   always #37 rc_clk_i = ~rc_clk_i;
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("Error %s: expected %h, seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] dt);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_dat_i <= {24'h000000, dt};
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 40);
      if (wb_ack_o !== 1'b1) fails++;
      q = wb_dat_o[7:0];
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask : wb

   function automatic logic [15:0] just_exp(input logic j, input logic [9:0] v);
      return j ? {6'h00, v} : {v, 6'h00};
   endfunction : just_exp

   function automatic logic pump_exp(input logic [1:0] md, input logic en, input logic up);
      return (md == PUMP_ON) || (md == PUMP_AUTO && !up) || (md == PUMP_ANA && en && !up);
   endfunction : pump_exp

   task automatic finish_conv(input logic ie);
      int          n;
      logic [15:0] e;
      n = 0;
      e = just_exp(jw, val);
      do begin
         wb(1'b0, IDX_CTRL0, 8'h00);
         n++;
      end while (q[GO_BIT] === 1'b1 && n < 30);
      chk("run bit", q[GO_BIT], 1'b0);
      chk("irq", irq_o, ie);
      wb(1'b0, IDX_STAT, 8'h00);
      chk("done flag", q[IRQ_DONE], 1'b1);
      chk("irq cleared", irq_o, 1'b0);
      wb(1'b0, IDX_RES_LO, 8'h00);
      chk("result low", q, e[7:0]);
      wb(1'b0, IDX_RES_HI, 8'h00);
      chk("result high", q, e[15:8]);
   endtask : finish_conv

   task automatic wrap_up();
      $display("comparisons %0d, mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : wrap_up

   initial begin
      #200000;
      fails++;
      wrap_up();
   end
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      void'($urandom(32'h2037));
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      for (int a = IDX_PUMP; a <= IDX_MASK; a++) begin
         wb(1'b0, a[7:0], 8'h00);
         chk("reset value", q & (a == IDX_PUMP ? 8'hC0 : 8'hFF), 8'h00);
      end
      wb(1'b1, 8'hB0, 8'hFF);
      wb(1'b0, 8'hB0, 8'h00);
      chk("unmapped", q, 8'h00);
      wb(1'b1, IDX_CTRL1, 8'hFF);
      wb(1'b0, IDX_CTRL1, 8'h00);
      chk("format reg", q, 8'hF3);
      for (int r = 0; r < 4; r++) begin
         wb(1'b1, IDX_CTRL1, r[7:0]);
         chk("reference", ref_sel_o, r == REF_RSVD ? 2'h0 : r[1:0]);
      end
      foreach (ch_tab[i]) begin
         wb(1'b1, IDX_CTRL0, {ch_tab[i][5:0], 2'b00});
         chk("channel", conv_chan_o, ch_tab[i][5:0]);
         chk("listed", chan_listed_o, ch_tab[i][6]);
         chk("conv off", conv_en_o, 1'b0);
      end
      repeat (4) begin
         d = $urandom;
         h = $urandom;
         wb(1'b1, IDX_RES_LO, d);
         wb(1'b1, IDX_RES_HI, h);
         wb(1'b0, IDX_RES_HI, 8'h00);
         chk("result rw high", q, h);
         wb(1'b0, IDX_RES_LO, 8'h00);
         chk("result rw low", q, d);
      end
      for (int k = 0; k < 8; k++) begin
         jw = k[0];
         val = $urandom;
         wb(1'b1, IDX_MASK, {7'h00, k[1]});
         wb(1'b1, IDX_CTRL1, {jw, k[2:0], 4'h0});
         wb(1'b1, IDX_CTRL0, 8'h01);
         chk("conv on", conv_en_o, 1'b1);
         // divided codes only: one full period between two rises
         if (k[1:0] != 2'b11) begin
            @(posedge conv_clk_o);
            t = $time;
            @(posedge conv_clk_o);
            chk("conv clock", 16'(($time - t) / CLK_NS), 16'h0002 << {k[1:0], k[2]});
         end
         wb(1'b1, IDX_CTRL0, 8'h03);
         wb(1'b0, IDX_CTRL0, 8'h00);
         chk("run set", q[GO_BIT], 1'b1);
         finish_conv(k[1]);
      end
      wb(1'b1, IDX_MASK, 8'h01);
      for (int c = 1; c <= 13; c++) begin
         if (c > 9 && c != 13) continue;
         val = $urandom;
         wb(1'b1, IDX_TRIG, c[7:0]);
         if (c == 13) wb(1'b0, IDX_RES_HI, 8'h00);
         else if (c == 1) begin
            trig_pin_i <= 1'b1;
            repeat (6) @(posedge clk_i);
            trig_pin_i <= 1'b0;
         end else begin
            trig_hw_i[c] <= 1'b1;
            @(posedge clk_i);
            trig_hw_i <= 8'h00;
         end
         wb(1'b1, IDX_TRIG, 8'h00);
         wb(1'b0, IDX_CTRL0, 8'h00);
         chk("trigger start", q[GO_BIT], 1'b1);
         finish_conv(1'b1);
      end
      repeat (16) begin
         {m, on, ab} = $urandom;
         wb(1'b1, IDX_CTRL0, {7'h00, on});
         wb(1'b1, IDX_PUMP, {m, 6'h00});
         supply_above_i <= ab;
         repeat (8) @(posedge clk_i);
         chk("pump enable", pump_en_o, pump_exp(m, on, ab));
         wb(1'b0, IDX_PUMP, 8'h00);
         chk("threshold", q[THR_BIT], ab);
         repeat (ST + 4) @(posedge clk_i);
         wb(1'b0, IDX_PUMP, 8'h00);
         chk("ready", q[RDY_BIT], pump_exp(m, on, ab));
      end
      wb(1'b1, IDX_PUMP, 8'hC0);
      repeat (4) @(posedge clk_i);
      chk("pump forced", pump_en_o, 1'b1);
      wb(1'b1, IDX_PUMP, 8'h00);
      repeat (4) @(posedge clk_i);
      chk("pump cleared", pump_en_o, 1'b0);
      wrap_up();
   end
endmodule : adc_control_and_pump_enable_tb
